/* File: vbc_command_handler.v */
/*
 contents: command handler of a dual regulator on a serial voltage-id bus;
 decodes frames, answers acknowledge codes, keeps per-regulator target,
 output code, power state, pointer and settled/alert state.
 assumes: link port framing in vbc_link_port; alert pin is open drain
 and pulled up outside; output code steps model the analog loop.
// How it works
// - regulator 0 answers only at address 0, regulator 1 only at 1.
// - broadcast addresses 1111b and 1110b reach both regulators.
// - fast target command sets target, ramps at the fast slew rate.
// - slow target command ramps at one quarter of the fast rate.
// - upward fast or slow target leaves low power for full power.
// - acknowledged upward target in low power clears power state to 00h.
// - reaching fast/slow target sets settled flag and pulls alert low.
// - fast/slow target commands preempt and move at once.
// - back-to-back target commands release alert after the acknowledge.
// - target equal to reached level asserts alert at once.
// - decay target moves down uncontrolled; settles without alert.
// - decay command preempts an upward fast or slow transition.
// - decay target above current setting is rejected, target kept.
// - power state byte bits select states; sets phases and skip.
// - unsupported power state gets not-supported and lowest state.
// - new power state is taken after its acknowledge is sent.
// - power state command while slewing fast or slow is rejected.
// - power state command during decay is taken, decay continues.
// - pointer command loads index; write commands use it repeatedly.
// - read command returns the indexed register in the answer.
// - pointer or read with unsupported index is rejected.
// - broadcast pointer, write or read get not-supported.
// - settled flag is status bit 0, zero while slewing.
// - target above the maximum register gets not-supported.
*/
`timescale 1ns/1ns
`include "vbc_defines.vh"

module vbc_command_handler
(
   // core clock and reset
   input  wire        clock,
   input  wire        reset_n,
   // link pins
   input  wire        linkClk,
   input  wire        linkSel,
   input  wire        linkDataIn,
   output wire        linkDataOut,
   output wire        linkDataOe_n,
   // alert pin, open drain
   output wire        alertOut,
   output reg         alertOe_n,
   // regulator controls, regulator 1 in the upper half
   output wire [15:0] outputCode,
   output wire [15:0] powerState,
   output wire [1:0]  settled,
   output wire [1:0]  singlePhase,
   output wire [1:0]  skipEnable
);

   // -------------------------------------------------------------------
   // link port and frame fields
   // -------------------------------------------------------------------
   wire [16:0] frameWord;
   wire        frameDone;
   wire        respDone;
   reg         respLoad_r;
   reg  [9:0]  respWord_r;
   reg  [1:0]  pendHit_r;
   wire [3:0]  addr;
   wire [4:0]  cmd;
   wire [7:0]  payload;
   wire        bcast;
   wire [1:0]  hit;
   wire [3:0]  ackAll;
   wire [15:0] rdAll;
   wire [1:0]  alertReq;
   wire        sel;

   vbc_link_port u_link
   (
      .clock        (clock),
      .reset_n      (reset_n),
      .linkClk      (linkClk),
      .linkSel      (linkSel),
      .linkDataIn   (linkDataIn),
      .linkDataOut  (linkDataOut),
      .linkDataOe_n (linkDataOe_n),
      .frameWord    (frameWord),
      .frameDone    (frameDone),
      .respLoad     (respLoad_r),
      .respWord     (respWord_r),
      .respDone     (respDone)
   );

   assign addr    = frameWord[16:13];
   assign cmd     = frameWord[12:8];
   assign payload = frameWord[7:0];
   // broadcast reaches both regulators
   assign bcast   = (addr == `VBC_ADDR_BCAST_A) |
                    (addr == `VBC_ADDR_BCAST_B);
   // fixed addresses, not programmable
   assign hit[0]  = bcast | (addr == `VBC_ADDR_REG0);
   assign hit[1]  = bcast | (addr == `VBC_ADDR_REG1);
   assign sel     = ~bcast & addr[0];
   assign alertOut = 1'b0;

   // -------------------------------------------------------------------
   // answer build: ack code and read payload of the addressed regulator
   // -------------------------------------------------------------------
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         respLoad_r <= 1'b0;
         respWord_r <= 10'h000;
         pendHit_r  <= 2'h0;
         alertOe_n  <= 1'b1;
      end
      else
      begin
         respLoad_r <= frameDone & (|hit);
         if (frameDone)
         begin
            pendHit_r <= hit;
            if (sel)
               respWord_r <= {ackAll[3:2], rdAll[15:8]};
            else
               respWord_r <= {ackAll[1:0], rdAll[7:0]};
         end
         alertOe_n <= ~(|alertReq);
      end
   end

   // -------------------------------------------------------------------
   // per-regulator register file and command execution
   // -------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : reg_file
         reg [7:0] target_r, level_r, voutMax_r, ps_r, psPend_r, ptr_r;
         reg       psPendV_r, settled_r, alertReq_r, alertRel_r;
         reg [1:0] mode_r;
         reg [9:0] slewCnt_r;
         reg [9:0] interval;
         reg [1:0] ack;
         reg [7:0] rdata;
         reg       idxOk;
         reg       psOk;
         reg [7:0] psCode;
         wire      exec;
         wire      ackDone;
         wire      slewing;

         assign exec    = frameDone & hit[g];
         assign ackDone = respDone & pendHit_r[g];
         // mode 1 fast, 2 slow, 3 decay, 0 idle
         assign slewing = (mode_r == 2'h1) | (mode_r == 2'h2);

         // index support, power state decode and register read mux
         always @*
         begin
            idxOk  = 1'b0;
            psOk   = 1'b1;
            psCode = `VBC_PS_LOWEST;
            rdata  = 8'h00;
            case (payload)
               `VBC_IDX_STATUS1, `VBC_IDX_FAST_SLEW, `VBC_IDX_SLOW_SLEW,
               `VBC_IDX_VOUT_MAX, `VBC_IDX_VID, `VBC_IDX_PSTATE,
               `VBC_IDX_POINTER:
                  idxOk = 1'b1;
               default:
                  idxOk = 1'b0;
            endcase
            // bit n of the byte selects state n; states 0..3 exist
            case (payload)
               8'h01:   psCode = 8'h00;
               8'h02:   psCode = 8'h01;
               8'h04:   psCode = 8'h02;
               8'h08:   psCode = 8'h03;
               default: psOk   = 1'b0;
            endcase
            case (payload)
               `VBC_IDX_STATUS1:   rdata = {7'h00, settled_r};
               `VBC_IDX_FAST_SLEW: rdata = `VBC_FAST_SLEW_VAL;
               `VBC_IDX_SLOW_SLEW: rdata = `VBC_SLOW_SLEW_VAL;
               `VBC_IDX_VOUT_MAX:  rdata = voutMax_r;
               `VBC_IDX_VID:       rdata = target_r;
               `VBC_IDX_PSTATE:    rdata = ps_r;
               `VBC_IDX_POINTER:   rdata = ptr_r;
               default:            rdata = 8'h00;
            endcase
         end

         // acknowledge code for the frame now in hand
         always @*
         begin
            ack = `VBC_ACK_OK;
            case (cmd)
               `VBC_CMD_FAST, `VBC_CMD_SLOW:
                  if (payload > voutMax_r)
                     ack = `VBC_ACK_NAK;
               `VBC_CMD_DECAY:
                  if (payload > voutMax_r)
                     ack = `VBC_ACK_NAK;
                  else if (payload > target_r)
                     ack = `VBC_ACK_REJ;
               `VBC_CMD_PS:
                  if (slewing && !settled_r)
                     ack = `VBC_ACK_REJ;
                  else if (!psOk)
                     ack = `VBC_ACK_NAK;
               `VBC_CMD_PTR, `VBC_CMD_RD:
                  if (bcast)
                     ack = `VBC_ACK_NAK;
                  else if (!idxOk)
                     ack = `VBC_ACK_REJ;
               `VBC_CMD_WR:
                  if (bcast)
                     ack = `VBC_ACK_NAK;
               default:
                  ack = `VBC_ACK_NAK;
            endcase
         end

         // cycles per code step for the running mode
         always @*
         begin
            case (mode_r)
               2'h1:    interval = `VBC_FAST_CYCLES - 10'h001;
               2'h2:    interval = `VBC_SLOW_CYCLES - 10'h001;
               default: interval = `VBC_DECAY_CYCLES - 10'h001;
            endcase
         end

         // command execution, ramp and settle
         always @(posedge clock)
         begin
            if (!reset_n)
            begin
               target_r   <= 8'h00;
               level_r    <= 8'h00;
               voutMax_r  <= `VBC_VOUT_MAX_RST;
               ps_r       <= 8'h00;
               psPend_r   <= 8'h00;
               psPendV_r  <= 1'b0;
               ptr_r      <= 8'h00;
               settled_r  <= 1'b0;
               alertReq_r <= 1'b0;
               alertRel_r <= 1'b0;
               mode_r     <= 2'h0;
               slewCnt_r  <= 10'h000;
            end
            else
            begin
               // ramp one code per interval toward the target
               if (mode_r != 2'h0 && level_r != target_r)
               begin
                  if (slewCnt_r >= interval)
                  begin
                     slewCnt_r <= 10'h000;
                     if (level_r < target_r)
                        level_r <= level_r + 8'h01;
                     else
                        level_r <= level_r - 8'h01;
                  end
                  else
                     slewCnt_r <= slewCnt_r + 10'h001;
               end
               // answer sent: release alert, take pending power state
               if (ackDone)
               begin
                  if (alertRel_r)
                     alertReq_r <= 1'b0;
                  alertRel_r <= 1'b0;
                  if (psPendV_r)
                     ps_r <= psPend_r;
                  psPendV_r <= 1'b0;
               end
               // arrival at target; set wins over the release above
               if (mode_r != 2'h0 && level_r == target_r)
               begin
                  settled_r <= 1'b1;
                  mode_r    <= 2'h0;
                  if (slewing)
                     alertReq_r <= 1'b1;
               end
               if (exec && ack == `VBC_ACK_OK)
               begin
                  case (cmd)
                     `VBC_CMD_FAST, `VBC_CMD_SLOW:
                     begin
                        target_r  <= payload;
                        slewCnt_r <= 10'h000;
                        mode_r    <= cmd[1:0];
                        psPendV_r <= 1'b0;
                        if (payload > level_r)
                           ps_r <= 8'h00;
                        if (payload == level_r)
                        begin
                           settled_r  <= 1'b1;
                           alertReq_r <= 1'b1;
                           mode_r     <= 2'h0;
                        end
                        else
                        begin
                           settled_r  <= 1'b0;
                           alertRel_r <= 1'b1;
                        end
                     end
                     `VBC_CMD_DECAY:
                     begin
                        target_r   <= payload;
                        slewCnt_r  <= 10'h000;
                        mode_r     <= 2'h3;
                        settled_r  <= (payload == level_r);
                        alertRel_r <= 1'b1;
                     end
                     `VBC_CMD_PS:
                     begin
                        psPend_r  <= psCode;
                        psPendV_r <= 1'b1;
                     end
                     `VBC_CMD_PTR:
                        ptr_r <= payload;
                     `VBC_CMD_WR:
                        case (ptr_r)
                           `VBC_IDX_VOUT_MAX: voutMax_r <= payload;
                           `VBC_IDX_PSTATE:   ps_r      <= payload;
                           `VBC_IDX_POINTER:  ptr_r     <= payload;
                           default:           ptr_r     <= ptr_r;
                        endcase
                     `VBC_CMD_RD:
                        // status read clears alert unless arrival sets it
                        if (payload == `VBC_IDX_STATUS1 &&
                            !(slewing && level_r == target_r))
                           alertReq_r <= 1'b0;
                     default:
                        mode_r <= mode_r;
                  endcase
               end
               else if (exec && cmd == `VBC_CMD_PS &&
                        ack == `VBC_ACK_NAK)
               begin
                  psPend_r  <= `VBC_PS_LOWEST;
                  psPendV_r <= 1'b1;
               end
            end
         end

         assign ackAll[2*g+1:2*g]   = ack;
         assign rdAll[8*g+7:8*g]    = (cmd == `VBC_CMD_RD) ? rdata : 8'h00;
         assign alertReq[g]         = alertReq_r;
         assign outputCode[8*g+7:8*g] = level_r;
         assign powerState[8*g+7:8*g] = ps_r;
         assign settled[g]          = settled_r;
         assign singlePhase[g]      = (ps_r != 8'h00);
         assign skipEnable[g]       = (ps_r >= 8'h02);
      end
   endgenerate

endmodule

/* File: vbc_defines.vh */
/*
 contents: constants of the voltage-id bus command handler, i.e. bus
 addresses, command codes, acknowledge codes, register indices, reset
 values and slew timing.
 assumes: included by bare name from the design files, 250 MHz clock.
*/
`ifndef VBC_DEFINES_VH
`define VBC_DEFINES_VH

// ----------------------------------------------------------------------
// frame layout and addressing
// ----------------------------------------------------------------------
`define VBC_FRAME_BITS      5'h11
`define VBC_RESP_BITS       4'hA
`define VBC_ADDR_REG0       4'h0
`define VBC_ADDR_REG1       4'h1
`define VBC_ADDR_BCAST_A    4'hF
`define VBC_ADDR_BCAST_B    4'hE

// ----------------------------------------------------------------------
// commands and acknowledge codes
// ----------------------------------------------------------------------
`define VBC_CMD_FAST        5'h01
`define VBC_CMD_SLOW        5'h02
`define VBC_CMD_DECAY       5'h03
`define VBC_CMD_PS          5'h04
`define VBC_CMD_PTR         5'h05
`define VBC_CMD_WR          5'h06
`define VBC_CMD_RD          5'h07
`define VBC_ACK_OK          2'h2
`define VBC_ACK_NAK         2'h1
`define VBC_ACK_REJ         2'h3

// ----------------------------------------------------------------------
// register indices and reset values
// ----------------------------------------------------------------------
`define VBC_IDX_STATUS1     8'h10
`define VBC_IDX_FAST_SLEW   8'h24
`define VBC_IDX_SLOW_SLEW   8'h25
`define VBC_IDX_VOUT_MAX    8'h30
`define VBC_IDX_VID         8'h31
`define VBC_IDX_PSTATE      8'h32
`define VBC_IDX_POINTER     8'h35
`define VBC_FAST_SLEW_VAL   8'h0A
`define VBC_SLOW_SLEW_VAL   8'h02
`define VBC_VOUT_MAX_RST    8'hFB
`define VBC_PS_LOWEST       8'h03
`define VBC_SETTLED_BIT     0

// ----------------------------------------------------------------------
// slew timing: one 5 mV code step at the programmed rate
// ----------------------------------------------------------------------
`define VBC_CLK_MHZ         250
`define VBC_STEP_MV         5
`define VBC_FAST_MV_PER_US  10
`define VBC_SLOW_DIVIDER    4
// one 5 mV step at 10 mV/us on 250 MHz is 125 cycles; slow takes 4 times
`define VBC_FAST_CYCLES     10'h07D
`define VBC_SLOW_CYCLES     10'h1F4
`define VBC_DECAY_CYCLES    10'h0FA

`endif

/* File: vbc_link_port.v */
/*
 contents: serial link port; samples link clock, select and data with the
 core clock, shifts in a 17-bit frame and shifts out a 10-bit answer.
 assumes: link clock much slower than core clock; data sampled on rising
 link edges, answer bits launched on falling link edges.
*/
`timescale 1ns/1ns
`include "vbc_defines.vh"

module vbc_link_port
(
   // core clock and reset
   input  wire        clock,
   input  wire        reset_n,
   // link pins
   input  wire        linkClk,
   input  wire        linkSel,
   input  wire        linkDataIn,
   output reg         linkDataOut,
   output reg         linkDataOe_n,
   // frame and answer to the command logic
   output reg  [16:0] frameWord,
   output reg         frameDone,
   input  wire        respLoad,
   input  wire [9:0]  respWord,
   output reg         respDone
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RECV = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_SEND = 2'h3;

   reg [1:0]  state_r;
   reg [4:0]  bitCnt_r;
   reg [9:0]  outSh_r;
   reg        clkS1_r, clkS2_r, clkS3_r;
   reg        selS1_r, selS2_r;
   reg        datS1_r, datS2_r;
   wire       clkRise;
   wire       clkFall;

   // two-flop synchronisers, third flop for edge finding
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         clkS1_r <= 1'b0;
         clkS2_r <= 1'b0;
         clkS3_r <= 1'b0;
         selS1_r <= 1'b0;
         selS2_r <= 1'b0;
         datS1_r <= 1'b0;
         datS2_r <= 1'b0;
      end
      else
      begin
         clkS1_r <= linkClk;
         clkS2_r <= clkS1_r;
         clkS3_r <= clkS2_r;
         selS1_r <= linkSel;
         selS2_r <= selS1_r;
         datS1_r <= linkDataIn;
         datS2_r <= datS1_r;
      end
   end

   assign clkRise = clkS2_r & ~clkS3_r;
   assign clkFall = ~clkS2_r & clkS3_r;

   // frame receive and answer transmit sequence
   always @(posedge clock)
   begin
      frameDone <= 1'b0;
      respDone  <= 1'b0;
      if (!reset_n)
      begin
         state_r      <= ST_IDLE;
         bitCnt_r     <= 5'h00;
         outSh_r      <= 10'h000;
         frameWord    <= 17'h0_0000;
         linkDataOut  <= 1'b0;
         linkDataOe_n <= 1'b1;
      end
      else if (!selS2_r)
      begin
         state_r      <= ST_IDLE;    // frame end aborts everything
         linkDataOe_n <= 1'b1;
         bitCnt_r     <= 5'h00;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               state_r  <= ST_RECV;
               bitCnt_r <= 5'h00;
            end
            ST_RECV:
            begin
               if (clkRise)
               begin
                  frameWord <= {frameWord[15:0], datS2_r};
                  bitCnt_r  <= bitCnt_r + 5'h01;
                  if (bitCnt_r == `VBC_FRAME_BITS - 5'h01)
                  begin
                     frameDone <= 1'b1;
                     state_r   <= ST_WAIT;
                  end
               end
            end
            ST_WAIT:
            begin
               if (respLoad)
               begin
                  outSh_r  <= respWord;
                  bitCnt_r <= 5'h00;
                  state_r  <= ST_SEND;
               end
            end
            ST_SEND:
            begin
               if (clkFall)
               begin
                  if (bitCnt_r == {1'b0, `VBC_RESP_BITS})
                  begin
                     linkDataOe_n <= 1'b1;
                     respDone     <= 1'b1;
                     state_r      <= ST_WAIT;  // idle until select drops
                  end
                  else
                  begin
                     linkDataOut  <= outSh_r[9];
                     linkDataOe_n <= 1'b0;
                     outSh_r      <= {outSh_r[8:0], 1'b0};
                     bitCnt_r     <= bitCnt_r + 5'h01;
                  end
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

endmodule

/* File: vbc_command_handler_sva.sv */
/*
 checker of the command handler ports: power state decode, ramp pacing,
 settled and alert timing, link drive.
 assumes: bound to vbc_command_handler, synchronous active-low reset.
*/
`timescale 1ns/1ns
module vbc_command_handler_sva
(
   // clock and reset
   input wire        clock,
   input wire        reset_n,
   // watched pins
   input wire        linkSel,
   input wire        linkDataOe_n,
   input wire        alertOe_n,
   input wire [15:0] outputCode,
   input wire [15:0] powerState,
   input wire [1:0]  settled,
   input wire [1:0]  singlePhase,
   input wire [1:0]  skipEnable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // phase and skip follow the stored power state
   a_phase_decode: assert property (
      singlePhase[0] == (|powerState[7:0])) else $error("phase decode");
   a_skip_decode: assert property (
      skipEnable[0] == (powerState[7:0] >= 8'h02)) else $error("skip");
   a_ps_range: assert property (
      powerState[7:0] <= 8'h03) else $error("power state range");
   // a code step is followed by a paced pause
   a_out_step: assert property (
      $changed(outputCode[7:0]) |=> $stable(outputCode[7:0])[*8])
      else $error("code step too fast");
   a_settled_slew: assert property (
      $changed(outputCode[7:0]) |-> !settled[0]) else $error("settled");
   a_alert_cause: assert property (
      $fell(alertOe_n) |-> |(settled | $past(settled)))
      else $error("alert without settle");
   // state and drive change only inside frames
   a_ps_in_frame: assert property (
      $changed(powerState) |-> $past(linkSel, 2)) else $error("ps change");
   a_oe_in_frame: assert property (
      !linkDataOe_n |-> $past(linkSel, 3)) else $error("drive outside");
   // main scenarios
   c_settle: cover property ($rose(settled[1]));
   c_alert: cover property ($fell(alertOe_n));
   c_skip: cover property ($rose(skipEnable[0]));
endmodule

/* File: vbc_master_model.sv */
/*
 bus master model: sends 17-bit frames and collects 10-bit answers.
 assumes: 48 ns link clock, still between frames.
*/
`timescale 1ns/1ns
module vbc_master_model
(
   // link pins
   output reg  linkClk,
   output reg  linkSel,
   output reg  linkDataIn,
   input  wire linkDataOut,
   input  wire linkDataOe_n
);
   // idle link
   initial
   begin
      linkClk = 1'b0;
      linkSel = 1'b0;
      linkDataIn = 1'b1;
   end
   // one frame; r = {device drove, ack, payload}
   task xfer(input [16:0] f, output [10:0] r);
      integer i;
      begin
         r = 11'h000;
         linkSel <= 1'b1;
         #40;
         for (i = 16; i >= 0; i = i - 1)
         begin
            #12 linkDataIn <= f[i];
            #12 linkClk <= 1'b1;
            #24 linkClk <= 1'b0;
         end
         for (i = 9; i >= 0; i = i - 1)
         begin
            #24 linkClk <= 1'b1;
            r[10] = r[10] | !linkDataOe_n;
            r[i] = !linkDataOe_n & linkDataOut;
            #24 linkClk <= 1'b0;
         end
         #60 linkSel <= 1'b0;
         linkDataIn <= ~linkDataIn; // toggled line, no stale value
         #40;
      end
   endtask
endmodule

/* File: vbc_command_handler_tb.sv */
/*
 testbench: each scenario task drives frames and judges answers; all but t_regs also judge pins.
 assumes: vbc_master_model as bus master, checker bound below.
*/
`timescale 1ns/1ns
module vbc_command_handler_tb;
   reg         clock;
   reg         reset_n;
   wire        linkClk, linkSel, linkDataIn, linkDataOut, linkDataOe_n;
   wire        alertOut, alertOe_n;
   wire [15:0] outputCode, powerState;
   wire [1:0]  settled, singlePhase, skipEnable;
   integer     mismatches, compares, cycles;
   reg  [10:0] resp;
   vbc_command_handler u_vbc_command_handler (.clock, .reset_n, .linkClk,
      .linkSel, .linkDataIn, .linkDataOut, .linkDataOe_n, .alertOut,
      .alertOe_n, .outputCode, .powerState, .settled, .singlePhase,
      .skipEnable);
   vbc_master_model u_vbc_master_model (.linkClk, .linkSel, .linkDataIn,
      .linkDataOut, .linkDataOe_n);
   // clock and hang limit
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         mismatches = mismatches + 1;
         finish_test;
      end
   end
   task chk(input [8*6-1:0] nm, input [15:0] e, input [15:0] g);
      begin
         compares = compares + 1;
         if (g !== e)
         begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // one frame; ack 0 means no answer expected
   task cmd(input [3:0] a, input [4:0] c, input [7:0] p, input [1:0] ea,
            input [7:0] ed);
      begin
         u_vbc_master_model.xfer({a, c, p}, resp);
         chk("answer", {5'h00, |ea, ea, ed}, {5'h00, resp});
      end
   endtask
   task wait_settled(input integer i, input integer n);
      integer k;
      begin
         k = 0;
         while (settled[i] !== 1'b1 && k < n)
         begin
            @(posedge clock);
            k = k + 1;
         end
         @(posedge clock); // let the alert pin follow the settle
         chk("settle", 16'h0001, {15'h0000, settled[i]});
      end
   endtask
   task t_regs;
      begin
         cmd(4'h0, 5'h07, 8'h24, 2'h2, 8'h0A);
         cmd(4'h0, 5'h07, 8'h25, 2'h2, 8'h02);
         cmd(4'h0, 5'h07, 8'h00, 2'h3, 8'h00);
         cmd(4'h0, 5'h05, 8'h07, 2'h3, 8'h00);
         cmd(4'hF, 5'h07, 8'h24, 2'h1, 8'h0A);
         cmd(4'hE, 5'h05, 8'h30, 2'h1, 8'h00);
         cmd(4'hF, 5'h06, 8'h00, 2'h1, 8'h00);
         cmd(4'h2, 5'h07, 8'h24, 2'h0, 8'h00);
      end
   endtask
   task t_ptr;
      begin
         cmd(4'h0, 5'h05, 8'h30, 2'h2, 8'h00);
         cmd(4'h0, 5'h06, 8'h03, 2'h2, 8'h00);
         cmd(4'h0, 5'h07, 8'h30, 2'h2, 8'h03);
         cmd(4'h0, 5'h01, 8'h04, 2'h1, 8'h00);
         cmd(4'h0, 5'h06, 8'hFB, 2'h2, 8'h00);
         cmd(4'h0, 5'h07, 8'h30, 2'h2, 8'hFB);
         chk("code", 16'h0000, outputCode);
      end
   endtask
   task t_reg1;
      begin
         cmd(4'h1, 5'h01, 8'h04, 2'h2, 8'h00);
         chk("code0", 16'h0000, {8'h00, outputCode[7:0]});
         wait_settled(1, 600);
         chk("code1", 16'h0004, {8'h00, outputCode[15:8]});
         chk("alert", 16'h0000, {15'h0000, alertOe_n});
         cmd(4'h1, 5'h07, 8'h10, 2'h2, 8'h01);
         chk("alert", 16'h0001, {15'h0000, alertOe_n});
         cmd(4'h1, 5'h01, 8'h04, 2'h2, 8'h00);
         chk("alert", 16'h0000, {15'h0000, alertOe_n});
         cmd(4'h1, 5'h01, 8'h0C, 2'h2, 8'h00);
         chk("alert", 16'h0001, {15'h0000, alertOe_n});
         cmd(4'h1, 5'h03, 8'h05, 2'h2, 8'h00);
         wait_settled(1, 2000);
         chk("code1", 16'h0005, {8'h00, outputCode[15:8]});
      end
   endtask
   task t_reg0;
      begin
         cmd(4'h0, 5'h04, 8'h04, 2'h2, 8'h00);
         chk("ps", 16'h0002, {8'h00, powerState[7:0]});
         chk("skip", 16'h0003, {14'h0000, skipEnable[0], singlePhase[0]});
         cmd(4'h0, 5'h04, 8'h80, 2'h1, 8'h00);
         chk("ps", 16'h0003, {8'h00, powerState[7:0]});
         cmd(4'h0, 5'h02, 8'h02, 2'h2, 8'h00);
         chk("ps", 16'h0000, {8'h00, powerState[7:0]});
         chk("code0", 16'h0000, {8'h00, outputCode[7:0]});
         cmd(4'h0, 5'h04, 8'h02, 2'h3, 8'h00);
         wait_settled(0, 1500);
         cmd(4'h0, 5'h03, 8'h05, 2'h3, 8'h00);
         chk("code0", 16'h0002, {8'h00, outputCode[7:0]});
         cmd(4'h0, 5'h03, 8'h00, 2'h2, 8'h00);
         cmd(4'h0, 5'h04, 8'h02, 2'h2, 8'h00);
         chk("ps", 16'h0001, {8'h00, powerState[7:0]});
         wait_settled(0, 800);
         chk("alert", 16'h0001, {15'h0000, alertOe_n});
         cmd(4'hE, 5'h01, 8'h06, 2'h2, 8'h00);
         chk("ps", 16'h0000, powerState);
         wait_settled(0, 1200);
         wait_settled(1, 400);
         chk("code", 16'h0606, outputCode);
      end
   endtask
   task finish_test;
      begin
         if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // reset, then the scenarios
   initial
   begin
      reset_n = 1'b0;
      mismatches = 0;
      compares = 0;
      cycles = 0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_regs;
      t_ptr;
      t_reg1;
      t_reg0;
      finish_test;
   end
endmodule
bind vbc_command_handler vbc_command_handler_sva u_vbc_command_handler_sva
   (.clock, .reset_n, .linkSel, .linkDataOe_n, .alertOe_n, .outputCode,
    .powerState, .settled, .singlePhase, .skipEnable);
